// file: raes_defines.svh
`ifndef RAES_DEFINES_SVH
`define RAES_DEFINES_SVH

// ----------------------------------------
// register offsets in the base io window
// ----------------------------------------
`define RAES_IACK_OFF      8'h0e
`define RAES_IACK_BAD_OFF  8'h0f
`define RAES_LSTAT_OFF     8'h0c
`define RAES_LCMD_OFF      8'h0d

// ----------------------------------------
// local error status fields
// ----------------------------------------
`define RAES_BIT_DATAERR   7
`define RAES_BIT_BUSERR    6
`define RAES_BIT_TIMEOUT   2
`define RAES_BIT_LINKDN    0
`define RAES_LSTAT_RST     8'h00
`define RAES_LCMD_CLR_BIT  0

// ----------------------------------------
// timing, clock 100 mhz
// ----------------------------------------
`define RAES_CLK_MHZ       100
`define RAES_PCI_NORESP    6
`define RAES_VME_TMO_US    48
`define RAES_P2V_TMO_US    30
`define RAES_V2P_TMO_US    40
`define RAES_OVERHEAD_US   2
`define RAES_DMA_TMO_MS    16
`define RAES_US_CYC        (`RAES_CLK_MHZ)
`define RAES_MS_CYC        (`RAES_CLK_MHZ * 1000)

`endif

// file: raes_pkg.sv
`default_nettype none

package raes_pkg;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] offset;
        logic       word;
    } raes_ioreq_type;

    typedef struct packed {
        logic        done;
        logic        berr;
        logic [15:0] data;
    } raes_resp_type;

    typedef enum logic [1:0] {
        RAES_SRC_P2V,
        RAES_SRC_V2P,
        RAES_SRC_DMA,
        RAES_SRC_IACK
    } raes_src_type;

endpackage

`default_nettype wire

// file: raes_sync.sv
`default_nettype none

module raes_sync (
    input  wire logic i_mclk,
    input  wire logic i_resetn,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_r;

    // first stage feeds only the second
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            meta_r <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

`default_nettype wire

// file: raes_timer.sv
`include "raes_defines.svh"
`default_nettype none

module raes_timer #(
    parameter int W = 24
) (
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    input  wire logic         i_run,
    input  wire logic [W-1:0] i_limit,
    output logic              o_expired
);
    logic [W-1:0] cnt_r;

    // counts while run holds, sticks at limit, restarts when run drops
    always_ff @(posedge i_mclk) begin
        if (!i_resetn || !i_run) begin
            cnt_r <= '0;
        end else if (cnt_r != i_limit) begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign o_expired = i_run && (cnt_r == i_limit);
endmodule

`default_nettype wire

// file: raes_top.sv
// Summary of operation
// - byte read at 0x0e of iack register runs an iack cycle, returns 8-bit vector.
// - word read at 0x0e runs an iack cycle and returns a 16-bit vector.
// - byte read at 0x0f is illegal: flag bus error and interface timeout.
// - iack to an idle level ends in bus error; pending levels are shown.
// - cable data check failure sets sticky data-error bit 7.
// - failed or improper remote cycle sets sticky bus-error bit 6.
// - pci access errs on target abort or no answer within six cycles.
// - vme access errs on berr or no answer within 48 us.
// - p2v cycle over 30 us ends locally, sets timeout; remote cycle continues.
// - late vme error is reported as bus error at the next remote access.
// - overrun sets bit 2; limit 30 us p2v, 40 us v2p.
// - dma transfers longer than 16 ms count as interface timeout.
// - timeout bit is sticky until command-register reset.
// - bit 0 shows remote power off or cable detached, self-clearing.
// - remote accesses while link is down fail with error bits.
// - ready indicator lights once logic loaded; unlit means no operation; status and unmapped io reads are still answered.
// - remote-activity indicator lit while a cable command is processed.
// - local-activity indicator lit while chassis address is recognised.
// - 2 us overhead leaves 28 us for a vme slave before timeout.
// - access to dual-port window without memory card ends in vme error.
`include "raes_defines.svh"
`default_nettype none

module raes_top
    import raes_pkg::*;
(
    input  wire logic                    i_mclk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_cfg_loaded,
    input  wire raes_pkg::raes_ioreq_type i_io_rd,
    input  wire logic                    i_io_wr,
    input  wire logic [7:0]              i_io_wr_off,
    input  wire logic [7:0]              i_io_wr_data,
    output logic                         o_io_done,
    output logic [15:0]                  o_io_rdata,
    input  wire logic                    i_rem_start,
    input  wire raes_pkg::raes_src_type  i_rem_src,
    input  wire logic                    i_rem_dpm_hit,
    input  wire raes_pkg::raes_resp_type i_rem_resp,
    input  wire logic                    i_pci_tabort,
    input  wire logic                    i_pci_devsel,
    input  wire logic                    i_dma_busy,
    output logic                         o_rem_done,
    output logic                         o_rem_fail,
    output logic                         o_iack_go,
    output logic                         o_iack_word,
    input  wire logic [7:1]              i_irq_levels,
    input  wire logic [2:0]              i_iack_level,
    input  wire logic                    i_dpm_fitted,
    input  wire logic                    i_cable_chk_err,
    input  wire logic                    i_link_up,
    input  wire logic                    i_local_addr_hit,
    output logic [7:1]                   o_iack_pending,
    output logic                         o_led_ready,
    output logic                         o_led_remote,
    output logic                         o_led_local
);
    import raes_pkg::*;

    // ----------------------------------------
    // timing constants
    // ----------------------------------------
    localparam logic [23:0] P2V_CYC  = 24'((`RAES_P2V_TMO_US - `RAES_OVERHEAD_US) * `RAES_US_CYC);
    localparam logic [23:0] V2P_CYC  = 24'(`RAES_V2P_TMO_US * `RAES_US_CYC);
    localparam logic [23:0] VME_CYC  = 24'(`RAES_VME_TMO_US * `RAES_US_CYC);
    localparam logic [23:0] PCI_CYC  = 24'(`RAES_PCI_NORESP);
    localparam logic [23:0] DMA_CYC  = 24'(`RAES_DMA_TMO_MS * `RAES_MS_CYC);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_DETACHED
    } raes_state_type;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic cfg_s, chk_s, link_s, lhit_s, irq_any;
    logic [7:1] irq_s;

    raes_sync u_cfg  (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_async(i_cfg_loaded),     .o_sync(cfg_s));
    raes_sync u_chk  (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_async(i_cable_chk_err),  .o_sync(chk_s));
    raes_sync u_link (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_async(i_link_up),        .o_sync(link_s));
    raes_sync u_lhit (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_async(i_local_addr_hit), .o_sync(lhit_s));

    for (genvar g = 1; g < 8; g++) begin : g_irq
        raes_sync u_irq (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_async(i_irq_levels[g]), .o_sync(irq_s[g]));
    end

    assign irq_any = irq_s[i_iack_level];

    // ----------------------------------------
    // remote access sequencer
    // ----------------------------------------
    raes_state_type state_r;
    raes_src_type   src_r;
    logic           running;
    logic           own_exp, resp_exp, dma_exp;
    logic [23:0]    own_lim, resp_lim;
    logic           iack_req, iack_bad, iack_rd;
    logic           late_berr_r;
    logic           fail_now, tmo_now, early_fail, iack_issue;

    assign running = (state_r == ST_BUSY);

    assign iack_rd  = i_io_rd.valid && (i_io_rd.offset == `RAES_IACK_OFF);
    assign iack_bad = i_io_rd.valid && (i_io_rd.offset == `RAES_IACK_BAD_OFF) && !i_io_rd.word;
    assign iack_req = iack_rd && state_r == ST_IDLE;

    always_comb begin
        own_lim  = P2V_CYC;
        resp_lim = VME_CYC;
        unique case (src_r)
            RAES_SRC_P2V:  begin own_lim = P2V_CYC; resp_lim = VME_CYC; end
            RAES_SRC_V2P:  begin own_lim = V2P_CYC; resp_lim = PCI_CYC; end
            RAES_SRC_DMA:  begin own_lim = DMA_CYC; resp_lim = DMA_CYC; end
            RAES_SRC_IACK: begin own_lim = P2V_CYC; resp_lim = VME_CYC; end
        endcase
    end

    raes_timer u_own (
        .i_mclk    (i_mclk),
        .i_resetn  (i_resetn),
        .i_run     (running),
        .i_limit   (own_lim),
        .o_expired (own_exp)
    );

    // pci no-answer window only until devsel, vme slave window keeps going
    raes_timer u_resp (
        .i_mclk    (i_mclk),
        .i_resetn  (i_resetn),
        .i_run     (running && !(src_r == RAES_SRC_V2P && i_pci_devsel)),
        .i_limit   (resp_lim),
        .o_expired (resp_exp)
    );

    raes_timer u_dma (
        .i_mclk    (i_mclk),
        .i_resetn  (i_resetn),
        .i_run     (i_dma_busy),
        .i_limit   (DMA_CYC),
        .o_expired (dma_exp)
    );

    assign fail_now = running && (i_rem_resp.berr
                    || (src_r == RAES_SRC_V2P && i_pci_tabort)
                    || (resp_exp && src_r != RAES_SRC_DMA));
    assign tmo_now  = running && own_exp && !i_rem_resp.done;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state_r <= ST_IDLE;
            src_r   <= RAES_SRC_P2V;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (!cfg_s) begin
                        state_r <= ST_IDLE;
                    end else if (early_fail) begin
                        state_r <= ST_IDLE;                    // refused requests never go busy
                    end else if (iack_req) begin
                        state_r <= ST_BUSY;
                        src_r   <= RAES_SRC_IACK;
                    end else if (i_rem_start) begin
                        state_r <= ST_BUSY;
                        src_r   <= i_rem_src;
                    end
                end
                ST_BUSY: begin
                    if (!link_s) begin
                        state_r <= ST_DETACHED;
                    end else if (i_rem_resp.done || fail_now || tmo_now) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_DETACHED: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // remote port outputs
    // ----------------------------------------
    // requests refused at once when link down, no dual-port card, bad iack, idle level
    assign early_fail = state_r == ST_IDLE && cfg_s && (
                          ((i_rem_start || iack_rd) && !link_s)
                        || (i_rem_start && i_rem_dpm_hit && !i_dpm_fitted)
                        || (iack_rd && !irq_any)
                        || iack_bad);
    assign iack_issue = iack_req && cfg_s && !early_fail;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rem_done  <= 1'b0;
            o_rem_fail  <= 1'b0;
            o_iack_go   <= 1'b0;
            o_iack_word <= 1'b0;
        end else begin
            o_iack_go   <= iack_issue;
            o_iack_word <= iack_issue ? i_io_rd.word : o_iack_word;
            o_rem_done  <= early_fail || (running && (i_rem_resp.done || fail_now || tmo_now || !link_s));
            o_rem_fail  <= early_fail || fail_now || tmo_now || (running && !link_s)
                        || (running && i_rem_resp.done && late_berr_r);
        end
    end

    // a berr landing after the local side gave up is kept for the next access
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            late_berr_r <= 1'b0;
        end else if (state_r == ST_IDLE && i_rem_resp.berr) begin
            late_berr_r <= 1'b1;
        end else if (running && i_rem_resp.done) begin
            late_berr_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // local error status
    // ----------------------------------------
    logic [7:0] lstat_r;
    logic       clr_cmd, set_data, set_bus, set_tmo;

    assign clr_cmd  = i_io_wr && i_io_wr_off == `RAES_LCMD_OFF && i_io_wr_data[`RAES_LCMD_CLR_BIT];
    assign set_data = chk_s;
    assign set_bus  = fail_now || early_fail
                   || (running && i_rem_resp.done && late_berr_r);
    assign set_tmo  = tmo_now || dma_exp || iack_bad
                   || (early_fail && !link_s);

    // set wins over clear, link bit untouched by the command
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            lstat_r <= `RAES_LSTAT_RST;
        end else begin
            if (set_data) begin
                lstat_r[`RAES_BIT_DATAERR] <= 1'b1;
            end else if (clr_cmd) begin
                lstat_r[`RAES_BIT_DATAERR] <= 1'b0;
            end
            if (set_bus) begin
                lstat_r[`RAES_BIT_BUSERR] <= 1'b1;
            end else if (clr_cmd) begin
                lstat_r[`RAES_BIT_BUSERR] <= 1'b0;
            end
            if (set_tmo) begin
                lstat_r[`RAES_BIT_TIMEOUT] <= 1'b1;
            end else if (clr_cmd) begin
                lstat_r[`RAES_BIT_TIMEOUT] <= 1'b0;
            end
            lstat_r[`RAES_BIT_LINKDN] <= !link_s;
        end
    end

    // ----------------------------------------
    // io read answers
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_io_done  <= 1'b0;
            o_io_rdata <= 16'h0000;
        end else begin
            o_io_done <= 1'b0;
            if (i_io_rd.valid && i_io_rd.offset == `RAES_LSTAT_OFF) begin
                o_io_done  <= 1'b1;
                o_io_rdata <= {8'h00, lstat_r};
            end else if (i_io_rd.valid && !iack_rd && !iack_bad) begin
                o_io_done  <= 1'b1;                                    // unmapped reads return zero
                o_io_rdata <= 16'h0000;
            end else if (src_r == RAES_SRC_IACK && running && i_rem_resp.done && !fail_now) begin
                o_io_done  <= 1'b1;
                o_io_rdata <= o_iack_word ? i_rem_resp.data
                                          : {8'h00, i_rem_resp.data[7:0]};
            end else if ((early_fail && (iack_rd || iack_bad))
                      || (src_r == RAES_SRC_IACK && (fail_now || tmo_now))) begin
                o_io_done  <= 1'b1;
                o_io_rdata <= 16'hffff;
            end
        end
    end

    // ----------------------------------------
    // indicators and pending levels
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_led_ready    <= 1'b0;
            o_led_remote   <= 1'b0;
            o_led_local    <= 1'b0;
            o_iack_pending <= 7'h00;
        end else begin
            o_led_ready    <= cfg_s;
            o_led_remote   <= running;
            o_led_local    <= lhit_s;
            o_iack_pending <= irq_s;
        end
    end
endmodule

`default_nettype wire

// file: raes_top_asserts.sv
`default_nettype none

// ----------------------------------------
// port checker
// ----------------------------------------
module raes_top_asserts
    import raes_pkg::*;
(
    input wire logic                     i_mclk,
    input wire logic                     i_resetn,
    input wire raes_pkg::raes_ioreq_type i_io_rd,
    input wire logic                     i_rem_start,
    input wire raes_pkg::raes_src_type   i_rem_src,
    input wire raes_pkg::raes_resp_type  i_rem_resp,
    input wire logic                     i_local_addr_hit,
    input wire logic                     o_io_done,
    input wire logic [15:0]              o_io_rdata,
    input wire logic                     o_rem_done,
    input wire logic                     o_rem_fail,
    input wire logic                     o_iack_go,
    input wire logic                     o_iack_word,
    input wire logic                     o_led_ready,
    input wire logic                     o_led_remote,
    input wire logic                     o_led_local
);
    timeunit 1ns;
    timeprecision 1ps;

    logic         busy_r;
    logic         iack_r;
    logic         wd_r;
    logic [12:0]  cnt_r;
    raes_src_type src_r;
    // 0x0e and 0x0f both start a remote iack attempt
    wire logic    take = o_led_ready && !busy_r && (i_rem_start || (i_io_rd.valid && i_io_rd.offset[7:1] == 7'h07));

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            busy_r <= 1'b0;
            cnt_r  <= 13'h0;
        end else if (take) begin
            busy_r <= 1'b1;
            cnt_r  <= 13'h0;
            src_r  <= i_rem_start ? i_rem_src : RAES_SRC_IACK;
        end else if (o_rem_done) begin
            busy_r <= 1'b0;
        end else if (busy_r) begin
            cnt_r <= cnt_r + 13'h1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            iack_r <= 1'b0;
        end else if (o_iack_go) begin
            iack_r <= 1'b1;
            wd_r   <= o_iack_word;
        end else if (o_io_done) begin
            iack_r <= 1'b0;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    iack_start_a: assert property ($rose(o_iack_go) |-> $past(i_io_rd.valid) && $past(i_io_rd.offset) == 8'h0e)
        else $error("iack start without read");
    iack_width_a: assert property (o_iack_go |-> o_iack_word == $past(i_io_rd.word))
        else $error("iack width wrong");
    iack_data_a: assert property (o_io_done && iack_r && !o_rem_fail |-> $past(i_rem_resp.done) &&
        o_io_rdata == (wd_r ? $past(i_rem_resp.data) : {8'h00, $past(i_rem_resp.data[7:0])})) else $error("iack data");
    fail_done_a: assert property (o_rem_fail |-> o_rem_done)
        else $error("fail without done");
    bad_off_a: assert property (take && i_io_rd.valid && i_io_rd.offset == 8'h0f && !i_io_rd.word
        |=> o_rem_fail && o_io_done && !o_iack_go) else $error("odd iack not refused");
    p2v_limit_a: assert property (busy_r && src_r == RAES_SRC_P2V |-> cnt_r <= 13'd2805)
        else $error("p2v overrun");
    v2p_limit_a: assert property (busy_r && src_r == RAES_SRC_V2P |-> cnt_r <= 13'd4005)
        else $error("v2p overrun");
    ready_gate_a: assert property (!o_led_ready && !$past(o_led_ready) |-> !o_rem_done && !o_iack_go && !o_io_done)
        else $error("access while not ready");
    remote_led_a: assert property (busy_r && cnt_r > 13'd3 |-> o_led_remote)
        else $error("remote led dark");
    local_on_a: assert property (i_local_addr_hit [*5] |-> o_led_local)
        else $error("local led dark");
    local_off_a: assert property (!i_local_addr_hit [*5] |-> !o_led_local)
        else $error("local led lit");

    cover property (o_iack_go ##[1:100] o_io_done);
    cover property (o_rem_fail && src_r == RAES_SRC_V2P);
    cover property (busy_r && cnt_r == 13'd2700);
endmodule

bind raes_top raes_top_asserts u_asserts (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_io_rd(i_io_rd), .i_rem_start(i_rem_start),
    .i_rem_src(i_rem_src), .i_rem_resp(i_rem_resp), .i_local_addr_hit(i_local_addr_hit),
    .o_io_done(o_io_done), .o_io_rdata(o_io_rdata), .o_rem_done(o_rem_done), .o_rem_fail(o_rem_fail),
    .o_iack_go(o_iack_go), .o_iack_word(o_iack_word), .o_led_ready(o_led_ready),
    .o_led_remote(o_led_remote), .o_led_local(o_led_local)
);

`default_nettype wire

// file: raes_remote_model.sv
`default_nettype none

// ----------------------------------------
// far card: answers after a set delay
// ----------------------------------------
module raes_remote_model
    import raes_pkg::*;
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_resetn,
    input  wire logic                   i_go,
    input  wire logic [12:0]            i_delay,
    input  wire logic                   i_berr,
    input  wire logic                   i_silent,
    input  wire logic [15:0]            i_data,
    output var raes_pkg::raes_resp_type o_resp
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        run_r;
    logic [12:0] cnt_r;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            run_r  <= 1'b0;
            cnt_r  <= 13'h0;
            o_resp <= '0;
        end else begin
            o_resp.done <= 1'b0;
            o_resp.berr <= 1'b0;
            // released data lines invert every cycle, so the answer is not held on the next cycle
            o_resp.data <= ~o_resp.data;
            if (i_go && !i_silent && !run_r) begin
                run_r <= 1'b1;
                cnt_r <= i_delay;
            end else if (run_r) begin
                // keeps running after the near end gave up
                cnt_r <= cnt_r - 13'h1;
                if (cnt_r <= 13'h1) begin
                    run_r       <= 1'b0;
                    o_resp.done <= 1'b1;
                    o_resp.berr <= i_berr;
                    o_resp.data <= i_data;
                end
            end
        end
    end
endmodule

`default_nettype wire

// file: raes_top_tb_top.sv
`default_nettype none

module raes_top_tb_top
    import raes_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clk, rstn, cfg, wr, start, dpm, tab, dsel, fit, cerr, lnk, lhit, berr, sil, f, w, rl, dma;
    logic           io_done, rem_done, rem_fail, go, gw, lr, lrem, lloc;
    logic [7:0]     woff, wdat;
    logic [7:1]     irq, pend;
    logic [2:0]     lvl;
    logic [12:0]    dly;
    logic [15:0]    rdat, pdat, d;
    raes_ioreq_type rq;
    raes_src_type   src;
    raes_resp_type  resp;
    int             failures = 0, checked = 0, seed, n, i;

    raes_top dut (
        .i_mclk(clk), .i_resetn(rstn), .i_cfg_loaded(cfg), .i_io_rd(rq), .i_io_wr(wr), .i_io_wr_off(woff),
        .i_io_wr_data(wdat), .o_io_done(io_done), .o_io_rdata(rdat), .i_rem_start(start), .i_rem_src(src),
        .i_rem_dpm_hit(dpm), .i_rem_resp(resp), .i_pci_tabort(tab), .i_pci_devsel(dsel), .i_dma_busy(dma),
        .o_rem_done(rem_done), .o_rem_fail(rem_fail), .o_iack_go(go), .o_iack_word(gw), .i_irq_levels(irq),
        .i_iack_level(lvl), .i_dpm_fitted(fit), .i_cable_chk_err(cerr), .i_link_up(lnk),
        .i_local_addr_hit(lhit), .o_iack_pending(pend), .o_led_ready(lr), .o_led_remote(lrem), .o_led_local(lloc)
    );
    raes_remote_model u_far (
        .i_mclk(clk), .i_resetn(rstn), .i_go(go | start), .i_delay(dly), .i_berr(berr),
        .i_silent(sil), .i_data(pdat), .o_resp(resp)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        checked++;
        if (s !== x) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] off, input logic wd, output logic [15:0] q);
        int k;
        @(negedge clk);
        rq = '{1'b1, off, wd};
        @(negedge clk);
        rq.valid = 1'b0;
        for (k = 0; k < 5000 && io_done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (io_done !== 1'b1) failures++;
        q = rdat;
    endtask
    task automatic stat(input logic [7:0] x);
        rd(8'h0c, 1'b0, d);
        chk(d, {8'h00, x});
    endtask
    task automatic clr;
        @(negedge clk);
        wr = 1'b1;
        woff = 8'h0d;
        wdat = 8'h01;
        @(negedge clk);
        wr = 1'b0;
        cyc(2);
    endtask
    // n counts edges from the taking edge to the one that shows done
    task automatic rem(input raes_src_type s, input logic h);
        @(negedge clk);
        start = 1'b1;
        src = s;
        dpm = h;
        @(negedge clk);
        start = 1'b0;
        n = 1;
        while (rem_done !== 1'b1 && n < 6000) begin
            @(posedge clk);
            #1;
            n++;
            if (n == 8) rl = lrem;
        end
        if (rem_done !== 1'b1) failures++;
        f = rem_fail;
    endtask
    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        failures++;
        conclude;
    end

    initial begin
        seed = 32'h487a;
        {rstn, cfg, wr, start, dpm, tab, cerr, lhit, berr, sil, rl, dma} = '0;
        {dsel, fit, lnk} = 3'b111;
        {rq, woff, wdat, irq, pdat} = '0;
        src = RAES_SRC_P2V;
        lvl = 3'h1;
        dly = 13'h2;
        cyc(6);
        rstn = 1'b1;
        cyc(4);
        chk(lr, 1'b0);
        cfg = 1'b1;
        cyc(6);
        chk(lr, 1'b1);
        stat(8'h00);
        $display("test reset done");
        for (i = 0; i < 7; i++) begin
            lvl = 3'(i + 1);
            irq = 7'($random(seed)) | (7'h01 << i);
            pdat = 16'($random(seed));
            dly = 13'h2 + 13'($random(seed) & 32'h3f);
            w = 1'($random(seed));
            cyc(6);
            chk({9'h0, pend}, {9'h0, irq});
            rd(8'h0e, w, d);
            chk(d, w ? pdat : {8'h00, pdat[7:0]});
        end
        lvl = 3'h3;
        irq = 7'h7b;
        cyc(6);
        rd(8'h0e, 1'b1, d);
        chk(d, 16'hffff);
        stat(8'h40);
        clr;
        rd(8'h0f, 1'b0, d);
        chk(d, 16'hffff);
        stat(8'h44);
        clr;
        stat(8'h00);
        $display("test iack done");
        dly = 13'd20;
        rem(RAES_SRC_P2V, 1'b0);
        chk(f, 1'b0);
        chk(rl, 1'b1);
        cyc(3);
        chk(lrem, 1'b0);
        berr = 1'b1;
        rem(RAES_SRC_P2V, 1'b0);
        chk(f, 1'b1);
        {fit, berr} = 2'b00;
        rem(RAES_SRC_P2V, 1'b1);
        chk(f, 1'b1);
        stat(8'h40);
        clr;
        fit = 1'b1;
        rem(RAES_SRC_P2V, 1'b1);
        chk(f, 1'b0);
        $display("test remote done");
        {dly, berr} = {13'd3000, 1'b1};
        rem(RAES_SRC_P2V, 1'b0);
        chk(f, 1'b1);
        chk(n >= 2795 && n <= 2806, 1'b1);
        rd(8'h0c, 1'b0, d);
        chk(d[2], 1'b1);
        cyc(300);
        {dly, berr} = {13'd10, 1'b0};
        rem(RAES_SRC_P2V, 1'b0);
        chk(f, 1'b1);
        rd(8'h0c, 1'b0, d);
        chk(d[6], 1'b1);
        clr;
        {sil, dsel} = 2'b10;
        rem(RAES_SRC_V2P, 1'b0);
        chk(f, 1'b1);
        chk(n >= 6 && n <= 9, 1'b1);
        {dsel, tab} = 2'b11;
        rem(RAES_SRC_V2P, 1'b0);
        chk(f, 1'b1);
        tab = 1'b0;
        rem(RAES_SRC_V2P, 1'b0);
        chk(n >= 3995 && n <= 4006, 1'b1);
        stat(8'h44);
        clr;
        {sil, dma} = 2'b01;
        rem(RAES_SRC_DMA, 1'b0);
        dma = 1'b0;
        chk(f, 1'b0);
        stat(8'h00);
        $display("test timeout done");
        cerr = 1'b1;
        cyc(5);
        cerr = 1'b0;
        cyc(5);
        stat(8'h80);
        clr;
        stat(8'h00);
        lnk = 1'b0;
        cyc(6);
        stat(8'h01);
        rem(RAES_SRC_P2V, 1'b0);
        chk(f, 1'b1);
        stat(8'h45);
        clr;
        stat(8'h01);
        lnk = 1'b1;
        cyc(6);
        stat(8'h00);
        lhit = 1'b1;
        cyc(5);
        chk(lloc, 1'b1);
        lhit = 1'b0;
        cyc(5);
        chk(lloc, 1'b0);
        $display("test link done");
        conclude;
    end
endmodule

`default_nettype wire
